// [hdl/fbp_flash_protect.sv]
// flash/eeprom layout, boot region protection and operation control
//
// Operation
// - arrays are 32-bit words of four bytes each
// - block is one-operation unit; page is a group of whole blocks
// - low density: 8 KB flash, 128 pages equal to 64-byte blocks
// - low density: up to 640 B eeprom, 64 B blocks, 11 option bytes
// - medium: up to 64 pages of four 128-byte blocks
// - medium: up to 1 KB eeprom, two pages, 13 option bytes
// - high: up to 256 pages of four 128-byte blocks
// - high: up to 2 KB eeprom, four pages, 15 option bytes
// - byte, fast byte, word, block and fast block programming
// - interrupt on operation done and on illegal program attempt
// - arrays stay on or power down in halt modes
// - boot region sized in whole pages by a configuration byte
// - boot region always write protected; unlock keys never clear it
// - size byte counts pages from program base 0x00_8000
// - size byte zero means no protected boot region
// - low density: protected pages equal the size byte
// - medium: size byte plus two pages when it exceeds one
// - medium: first two pages hold 128 bytes of vectors
// - size byte written only via debug port in circuit mode
// - zero wait states to 16 MHz, one wait state option above
`timescale 1ns/100ps
`default_nettype none

module fbp_flash_protect #(
  parameter fbp_pkg::fbp_density_e DENSITY = fbp_pkg::FBP_MED,
  parameter int PROG_KB = 32,
  parameter int EE_BYTES = fbp_pkg::MED_EE_BYTES,
  parameter int PROG_CYCLES = 600,
  parameter int FAST_CYCLES = 300
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [fbp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [fbp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fbp_pkg::DATA_W-1:0] reg_rdata,
  // option byte values from the option array
  input wire logic [7:0] opt_boot_region_size,
  input wire logic opt_wait_state,
  // debug port option write
  input wire logic in_circuit_programming_mode,
  input wire logic dbg_opt_wr,
  input wire logic [7:0] dbg_opt_data,
  output logic boot_size_prog,
  output logic [7:0] boot_size_prog_data,
  // unlock state from the key logic
  input wire logic prog_unlocked,
  input wire logic data_unlocked,
  // program and erase requests from the cpu
  input wire logic op_req,
  input wire fbp_pkg::fbp_req_s op_cmd,
  output logic op_busy,
  // array command
  output logic arr_go,
  output fbp_pkg::fbp_req_s arr_cmd,
  // memory read timing
  input wire logic mem_rd,
  output logic mem_rd_ack,
  // power control
  input wire logic halt_mode,
  output logic arr_power_down,
  // event line
  output logic irq
);
  import fbp_pkg::*;

  // ****************************************
  // geometry
  // ****************************************
  localparam int PAGE_BYTES = (DENSITY == FBP_LOW) ?
    LOW_BLOCK_BYTES * LOW_BLOCKS_PER_PAGE :
    HD_BLOCK_BYTES * HD_BLOCKS_PER_PAGE;
  localparam int BLOCK_BYTES = (DENSITY == FBP_LOW) ?
    LOW_BLOCK_BYTES : HD_BLOCK_BYTES;
  localparam int MAX_PAGES = (DENSITY == FBP_LOW) ? LOW_PAGES :
    (DENSITY == FBP_MED) ? MED_PAGES : HIGH_PAGES;
  localparam int EE_MAX = (DENSITY == FBP_LOW) ? LOW_EE_BYTES :
    (DENSITY == FBP_MED) ? MED_EE_BYTES : HIGH_EE_BYTES;
  localparam int OPT_USED = (DENSITY == FBP_LOW) ? LOW_OPT_USED :
    (DENSITY == FBP_MED) ? MED_OPT_USED : HIGH_OPT_USED;
  localparam int PROG_BYTES = PROG_KB * 1024;
  localparam logic [ADDR_W-1:0] PROG_END =
    PROG_BASE + ADDR_W'(PROG_BYTES);
  localparam logic [ADDR_W-1:0] EE_BASE = 24'h00_4000;
  localparam logic [ADDR_W-1:0] EE_END = EE_BASE + ADDR_W'(EE_BYTES);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam int VEC_SPAN = VEC_PAGES * PAGE_BYTES;

  // refuse layouts that no variant has
  if (PROG_BYTES > MAX_PAGES * PAGE_BYTES ||
      (DENSITY == FBP_LOW && PROG_KB != LOW_PROG_KB) ||
      EE_BYTES > EE_MAX || EE_BYTES % BLOCK_BYTES != 0 ||
      OPT_USED > BLOCK_BYTES || FAST_CYCLES < 1 ||
      FAST_CYCLES > PROG_CYCLES) begin : g_bad_cfg
    $error("fbp_flash_protect: unsupported layout parameters");
  end

  // the vector pages open every region, so the array must hold them
  if (VEC_SPAN > PROG_BYTES) begin : g_bad_vec
    $error("fbp_flash_protect: vector pages exceed the array");
  end

  // ****************************************
  // functions
  // ****************************************
  // pages held by the boot region for a given size byte
  // a size of one stays one page; larger sizes add the vector pages except at low density
  function automatic logic [8:0] prot_pages(input logic [7:0] sz);
    logic [8:0] n;
    n = {1'b0, sz};
    if (DENSITY != FBP_LOW && sz > 8'h01) begin
      n = 9'({1'b0, sz} + 9'(MED_EXTRA_PAGES));
    end
    return n;
  endfunction

  // first address after the protected boot region
  function automatic logic [ADDR_W-1:0] prot_end(input logic [7:0] sz);
    logic [ADDR_W-1:0] span;
    span = ADDR_W'(prot_pages(sz)) * ADDR_W'(PAGE_BYTES);
    return PROG_BASE + span;
  endfunction

  // address aligned to a power-of-two unit
  function automatic logic aligned(input logic [ADDR_W-1:0] a,
                                   input int unsigned bytes);
    return (a & ADDR_W'(bytes - 1)) == '0;
  endfunction

  // ****************************************
  // option latch after reset
  // ****************************************
  logic loaded_q;
  logic [7:0] boot_size_q;
  logic ws_q;
  logic [ADDR_W-1:0] prot_end_q;

  // later option changes wait for the next reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loaded_q <= 1'b0;
      boot_size_q <= 8'h00;
      ws_q <= 1'b0;
      prot_end_q <= PROG_BASE;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      boot_size_q <= opt_boot_region_size;
      ws_q <= opt_wait_state;
      prot_end_q <= prot_end(opt_boot_region_size);
    end
  end

  // ****************************************
  // debug port size write
  // ****************************************
  // a new size goes to the option array and takes effect at next reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boot_size_prog <= 1'b0;
      boot_size_prog_data <= 8'h00;
    end else begin
      boot_size_prog <= dbg_opt_wr && in_circuit_programming_mode;
      if (dbg_opt_wr && in_circuit_programming_mode) begin
        boot_size_prog_data <= dbg_opt_data;
      end
    end
  end

  // ****************************************
  // request check
  // ****************************************
  logic in_prog;
  logic in_ee;
  logic in_boot;
  logic unit_ok;
  logic req_legal;

  always_comb begin
    in_prog = op_cmd.addr >= PROG_BASE && op_cmd.addr < PROG_END;
    in_ee = op_cmd.addr >= EE_BASE && op_cmd.addr < EE_END;
    // unlock keys play no part in the boot region test
    in_boot = op_cmd.addr >= PROG_BASE &&
              op_cmd.addr < prot_end_q;
    unique case (op_cmd.op)
      FBP_OP_BYTE, FBP_OP_FAST_BYTE: unit_ok = 1'b1;
      FBP_OP_WORD: unit_ok = aligned(op_cmd.addr, WORD_BYTES);
      FBP_OP_BLOCK, FBP_OP_FAST_BLOCK, FBP_OP_ERASE:
        unit_ok = aligned(op_cmd.addr, BLOCK_BYTES);
      default: unit_ok = 1'b0;
    endcase
    req_legal = unit_ok && !in_boot &&
                ((in_prog && prog_unlocked) ||
                 (in_ee && data_unlocked));
  end

  // ****************************************
  // operation sequencer
  // ****************************************
  typedef enum logic [1:0] {
    FBP_IDLE = 2'b00,
    FBP_PROG = 2'b01,
    FBP_DONE = 2'b11
  } fbp_state_e;

  fbp_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic take;
  logic illegal_ev;
  logic done_ev;

  // a request while busy or in the done cycle is dropped, not queued;
  // software has to wait for busy low before the next one
  assign take = op_req && loaded_q && state_q == FBP_IDLE;
  assign illegal_ev = take && !req_legal;
  assign done_ev = state_q == FBP_DONE;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= FBP_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        FBP_IDLE: begin
          if (take && req_legal) begin
            state_q <= FBP_PROG;
            // erase-free modes finish sooner
            if (op_cmd.op == FBP_OP_FAST_BYTE ||
                op_cmd.op == FBP_OP_FAST_BLOCK) begin
              cnt_q <= CNT_W'(FAST_CYCLES - 1);
            end else begin
              cnt_q <= CNT_W'(PROG_CYCLES - 1);
            end
          end
        end
        FBP_PROG: begin
          if (cnt_q == '0) begin
            state_q <= FBP_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        FBP_DONE: state_q <= FBP_IDLE;
        // the unused code falls back to idle
        default: state_q <= FBP_IDLE;
      endcase
    end
  end

  // array command issues only for a legal request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arr_go <= 1'b0;
      arr_cmd <= '0;
      op_busy <= 1'b0;
    end else begin
      arr_go <= take && req_legal;
      if (take && req_legal) begin
        arr_cmd <= op_cmd;
      end
      op_busy <= (state_q != FBP_IDLE && !done_ev) ||
                 (take && req_legal);
    end
  end

  // ****************************************
  // read wait states
  // ****************************************
  // one extra cycle when the wait option is set
  // the ack stands for one cycle only
  logic rd_wait_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_wait_q <= 1'b0;
      mem_rd_ack <= 1'b0;
    end else begin
      rd_wait_q <= mem_rd && ws_q;
      mem_rd_ack <= (mem_rd && !ws_q) || rd_wait_q;
    end
  end

  // ****************************************
  // control, status and event line
  // ****************************************
  logic [2:0] ctrl_q;
  logic done_flag_q;
  logic ill_flag_q;
  logic rd_status;

  assign rd_status = reg_rd && reg_addr == REG_STATUS;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata[2:0];
    end
  end

  // flags clear on status read; a new event in that cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_flag_q <= 1'b0;
      ill_flag_q <= 1'b0;
    end else begin
      done_flag_q <= done_ev || (done_flag_q && !rd_status);
      ill_flag_q <= illegal_ev || (ill_flag_q && !rd_status);
    end
  end

  // level output: stays while an enabled flag is set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (ctrl_q[CTRL_IE_DONE] &&
              (done_ev || (done_flag_q && !rd_status))) ||
             (ctrl_q[CTRL_IE_ILLEGAL] &&
              (illegal_ev || (ill_flag_q && !rd_status)));
    end
  end

  // power down only while halted and allowed by software
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arr_power_down <= 1'b0;
    end else begin
      arr_power_down <= halt_mode && ctrl_q[CTRL_PD_HALT];
    end
  end

  // ****************************************
  // register read
  // ****************************************
  logic [DATA_W-1:0] rd_d;

  always_comb begin
    rd_d = '0;
    unique case (reg_addr)
      REG_CTRL: rd_d = {5'h00, ctrl_q};
      REG_STATUS: begin
        rd_d[ST_DONE] = done_flag_q;
        rd_d[ST_ILLEGAL] = ill_flag_q;
        rd_d[ST_BUSY] = state_q != FBP_IDLE;
        rd_d[ST_WS] = ws_q;
      end
      REG_BOOT_SIZE: rd_d = boot_size_q;
      REG_GEOM: rd_d = {6'h00, DENSITY};
      default: rd_d = '0;
    endcase
  end

  // zero outside the answer cycle so stale data never looks fresh
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

`default_nettype wire

// [include/fbp_pkg.sv]
// shared constants and types for the flash boot protect block
package fbp_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int WORD_W = 32;
  localparam int REG_AW = 4;

  // ****************************************
  // memory layout
  // ****************************************
  localparam logic [ADDR_W-1:0] PROG_BASE = 24'h00_8000;
  localparam int WORD_BYTES = 4;
  localparam int LOW_PROG_KB = 8;
  localparam int LOW_PAGES = 128;
  localparam int LOW_BLOCK_BYTES = 64;
  localparam int LOW_BLOCKS_PER_PAGE = 1;
  localparam int LOW_EE_BYTES = 640;
  localparam int LOW_OPT_USED = 11;
  localparam int MED_PAGES = 64;
  localparam int MED_EE_BYTES = 1024;
  localparam int MED_OPT_USED = 13;
  localparam int HIGH_PAGES = 256;
  localparam int HIGH_EE_BYTES = 2048;
  localparam int HIGH_OPT_USED = 15;
  localparam int HD_BLOCK_BYTES = 128;
  localparam int HD_BLOCKS_PER_PAGE = 4;
  localparam int VEC_PAGES = 2;
  localparam int MED_EXTRA_PAGES = 2;

  // ****************************************
  // access timing
  // ****************************************
  localparam int NO_WS_MAX_MHZ = 16;
  localparam int ONE_WS_MAX_MHZ = 24;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
  localparam logic [REG_AW-1:0] REG_BOOT_SIZE = 4'h2;
  localparam logic [REG_AW-1:0] REG_GEOM = 4'h3;
  localparam int CTRL_PD_HALT = 0;
  localparam int CTRL_IE_DONE = 1;
  localparam int CTRL_IE_ILLEGAL = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int ST_DONE = 0;
  localparam int ST_ILLEGAL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_WS = 3;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    FBP_LOW = 2'h0,
    FBP_MED = 2'h1,
    FBP_HIGH = 2'h2
  } fbp_density_e;

  typedef enum logic [2:0] {
    FBP_OP_BYTE = 3'h0,
    FBP_OP_FAST_BYTE = 3'h1,
    FBP_OP_WORD = 3'h2,
    FBP_OP_BLOCK = 3'h3,
    FBP_OP_FAST_BLOCK = 3'h4,
    FBP_OP_ERASE = 3'h5
  } fbp_op_e;

  typedef struct packed {
    fbp_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } fbp_req_s;

endpackage

// [sim/fbp_cpu_model.sv]
// cpu core model issuing program requests and memory reads
`timescale 1ns/100ps
`default_nettype none
module fbp_cpu_model (
  // clock
  input wire logic sys_clk,
  // requests
  output logic op_req,
  output fbp_pkg::fbp_req_s op_cmd,
  output logic mem_rd,
  // answers
  input wire logic op_busy,
  input wire logic arr_go,
  input wire fbp_pkg::fbp_req_s arr_cmd,
  input wire logic mem_rd_ack
);
  import fbp_pkg::*;
  initial begin
    op_req = 1'b0;
    op_cmd = '0;
    mem_rd = 1'b0;
  end
  task automatic issue(input fbp_req_s c, output logic go,
    output fbp_req_s seen, output int busy_n);
    int n;
    @(posedge sys_clk);
    op_req <= 1'b1;
    op_cmd <= c;
    @(posedge sys_clk);
    op_req <= 1'b0;
    // released command lines must not look valid
    op_cmd <= ~c;
    @(negedge sys_clk);
    go = arr_go;
    seen = arr_cmd;
    n = 0;
    while (op_busy === 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    busy_n = n;
  endtask
  task automatic mem_read(output int lat);
    @(posedge sys_clk);
    mem_rd <= 1'b1;
    @(posedge sys_clk);
    mem_rd <= 1'b0;
    @(negedge sys_clk);
    lat = (mem_rd_ack === 1'b1) ? 1 : 0;
    @(negedge sys_clk);
    if (lat == 0 && mem_rd_ack === 1'b1) lat = 2;
  endtask
endmodule
`default_nettype wire

// [sim/fbp_flash_protect_bench.sv]
// self-checking bench for the flash boot protect block
`timescale 1ns/100ps
`default_nettype none
module fbp_flash_protect_bench;
  import fbp_pkg::*;
  localparam int PAGE = HD_BLOCK_BYTES * HD_BLOCKS_PER_PAGE;
  localparam int PROG_N = 4;
  localparam int FAST_N = 2;
  logic sys_clk, rst, reg_wr, reg_rd, opt_wait_state, halt_mode, irq;
  logic [REG_AW-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, dbg_opt_data, boot_size_prog_data;
  logic [7:0] opt_boot_region_size, d;
  logic in_circuit_programming_mode, dbg_opt_wr, boot_size_prog;
  logic prog_unlocked, data_unlocked, op_req, op_busy, arr_go, mem_rd;
  logic mem_rd_ack, arr_power_down;
  fbp_req_s op_cmd, arr_cmd;
  int num_errors = 0, n_compared = 0, seed = 32'h8e49_e056;
  int ctrl, lat, p, a, r;
  int sizes[3] = '{0, 1, 3};
  fbp_flash_protect #(.PROG_CYCLES(PROG_N), .FAST_CYCLES(FAST_N)) dut (.*);
  fbp_cpu_model cpu (.*);
  // ****
  // helpers
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string w, input logic [63:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic reg_wr_t(input logic [REG_AW-1:0] ad, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_rd_t(input logic [REG_AW-1:0] ad, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask
  task automatic do_reset(input int sz, input logic ws);
    @(posedge sys_clk);
    rst <= 1'b1;
    opt_boot_region_size <= sz[7:0];
    opt_wait_state <= ws;
    ctrl = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  function automatic logic legal(fbp_op_e op, int ad, int sz, logic pu,
    logic du);
    int pg;
    pg = (sz > 1) ? sz + 2 : sz;
    if (op == FBP_OP_WORD && ad % WORD_BYTES != 0) return 1'b0;
    if (op >= FBP_OP_BLOCK && ad % HD_BLOCK_BYTES != 0) return 1'b0;
    if (ad >= PROG_BASE && ad < PROG_BASE + pg * PAGE) return 1'b0;
    if (ad >= PROG_BASE && ad < PROG_BASE + 32 * 1024) return pu;
    if (ad >= 16'h4000 && ad < 16'h4000 + MED_EE_BYTES) return du;
    return 1'b0;
  endfunction
  task automatic run_op(input fbp_op_e op, input int ad, input int sz);
    fbp_req_s c, seen;
    logic go, ok;
    int busy_n, busy_e;
    c.op = op;
    c.addr = ad[ADDR_W-1:0];
    c.data = $random(seed);
    cpu.issue(c, go, seen, busy_n);
    // unlock levels set just before the call have settled by now
    ok = legal(op, ad, sz, prog_unlocked, data_unlocked);
    busy_e = (op == FBP_OP_FAST_BYTE || op == FBP_OP_FAST_BLOCK) ?
      FAST_N + 1 : PROG_N + 1;
    @(negedge sys_clk);
    chk("arr_go", ok, go);
    chk("busy_cycles", ok ? busy_e : 0, busy_n);
    if (ok) chk("arr_cmd", c, seen);
    chk("irq", ok ? ctrl[1] : ctrl[2], irq);
    reg_rd_t(REG_STATUS, d);
    chk("status", {~ok, ok}, d[1:0]);
    chk("power_down", halt_mode & ctrl[0], arr_power_down);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    {rst, reg_wr, reg_rd, halt_mode, dbg_opt_wr} = 5'h1f & 5'h10;
    {reg_addr, reg_wdata, dbg_opt_data} = '0;
    {in_circuit_programming_mode, prog_unlocked, data_unlocked} = '0;
    {opt_boot_region_size, opt_wait_state} = '0;
    foreach (sizes[i]) begin
      do_reset(sizes[i], i == 2);
      reg_rd_t(REG_BOOT_SIZE, d);
      chk("boot_size", sizes[i], d);
      reg_rd_t(REG_GEOM, d);
      chk("geom", FBP_MED, d);
      reg_rd_t(REG_STATUS, d);
      chk("ws_flag", i == 2, d[3]);
      reg_rd_t(4'h9, d);
      chk("unmapped", 0, d);
      cpu.mem_read(lat);
      chk("latency", 1 + (i == 2), lat);
      @(posedge sys_clk);
      prog_unlocked <= 1'b1;
      data_unlocked <= 1'b1;
      p = (sizes[i] > 1) ? sizes[i] + 2 : sizes[i];
      run_op(FBP_OP_ERASE, PROG_BASE + p * PAGE, sizes[i]);
      if (p > 0) run_op(FBP_OP_BYTE, PROG_BASE + p * PAGE - 1, sizes[i]);
      $display("boot size %0d test done", sizes[i]);
    end
    @(posedge sys_clk);
    opt_wait_state <= 1'b0;
    opt_boot_region_size <= 8'h00;
    reg_wr_t(REG_BOOT_SIZE, 8'h00);
    reg_rd_t(REG_BOOT_SIZE, d);
    chk("size_held", 3, d);
    cpu.mem_read(lat);
    chk("latency_held", 2, lat);
    $display("latch test done");
    repeat (30) begin
      r = $random(seed);
      ctrl = r[5:3];
      reg_wr_t(REG_CTRL, ctrl[7:0]);
      prog_unlocked <= r[0];
      data_unlocked <= r[1];
      halt_mode <= r[2];
      a = 16'h3f80 + r[30:16] % 16'h5100;
      if (r[9]) a[6:0] = '0;
      run_op(fbp_op_e'(r[8:6] % 6), a, 3);
    end
    $display("random operation test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      in_circuit_programming_mode <= k[0];
      dbg_opt_wr <= 1'b1;
      dbg_opt_data <= 8'h5a + k[7:0];
      @(posedge sys_clk);
      dbg_opt_wr <= 1'b0;
      @(negedge sys_clk);
      chk("size_prog", k, boot_size_prog);
      if (k == 1) chk("size_data", 8'h5b, boot_size_prog_data);
    end
    reg_rd_t(REG_BOOT_SIZE, d);
    chk("size_after_debug", 3, d);
    $display("debug write test done");
    wrap_up();
  end
endmodule
`default_nettype wire

// [sim/fbp_flash_protect_checker.sv]
// port assertions for the flash boot protect block
`timescale 1ns/100ps
`default_nettype none
module fbp_chk #(
  parameter int PROG_CYCLES = 600,
  parameter int FAST_CYCLES = 300
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // watched ports
  input wire logic reg_rd,
  input wire logic [fbp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [7:0] opt_boot_region_size,
  input wire logic in_circuit_programming_mode,
  input wire logic dbg_opt_wr,
  input wire logic [7:0] dbg_opt_data,
  input wire logic boot_size_prog,
  input wire logic [7:0] boot_size_prog_data,
  input wire logic op_req,
  input wire logic op_busy,
  input wire logic arr_go,
  input wire fbp_pkg::fbp_req_s arr_cmd,
  input wire logic mem_rd,
  input wire logic mem_rd_ack,
  input wire logic halt_mode,
  input wire logic arr_power_down
);
  import fbp_pkg::*;
  localparam int BUSY_MAX = PROG_CYCLES + 4;
  localparam int PAGE = HD_BLOCK_BYTES * HD_BLOCKS_PER_PAGE;
  int prot_end;
  int busy_n_q;
  logic size_got_q;
  logic [7:0] size_q;
  // the region follows the size seen at the first edge after reset
  assign prot_end = PROG_BASE + PAGE * ((size_q > 1) ?
    size_q + 2 : size_q);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      size_got_q <= 1'b0;
      size_q <= 8'h00;
    end else if (!size_got_q) begin
      size_got_q <= 1'b1;
      size_q <= opt_boot_region_size;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_n_q <= 0;
    end else begin
      busy_n_q <= op_busy ? busy_n_q + 1 : 0;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence dbg_req_s;
    dbg_opt_wr && in_circuit_programming_mode;
  endsequence
  sequence start_s;
    arr_go && op_busy;
  endsequence
  read_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  size_write_a:
    assert property (dbg_req_s |=> boot_size_prog &&
      boot_size_prog_data == $past(dbg_opt_data))
    else $error("size byte write not passed on");
  size_guard_a:
    assert property (boot_size_prog |->
      $past(dbg_opt_wr && in_circuit_programming_mode))
    else $error("size byte written outside debug mode");
  go_cause_a:
    assert property (arr_go |-> $past(op_req) && !$past(op_busy))
    else $error("array start without request");
  go_start_a:
    assert property ($rose(op_busy) |-> start_s ##1 !arr_go)
    else $error("start pulse wrong");
  boot_guard_a:
    assert property (arr_go |-> arr_cmd.addr < PROG_BASE ||
      arr_cmd.addr >= prot_end)
    else $error("write into boot region started");
  busy_bound_a:
    assert property ($rose(op_busy) |-> ##[1:BUSY_MAX] !op_busy)
    else $error("operation never completes");
  busy_min_a:
    assert property ($fell(op_busy) |-> busy_n_q >= FAST_CYCLES)
    else $error("operation ended too early");
  read_wait_a:
    assert property (mem_rd |-> ##[1:2] mem_rd_ack)
    else $error("memory read not acknowledged");
  ack_cause_a:
    assert property (mem_rd_ack |-> $past(mem_rd) || $past(mem_rd, 2))
    else $error("stray read acknowledge");
  power_cause_a:
    assert property (arr_power_down |-> $past(halt_mode))
    else $error("power down outside halt");
endmodule
bind fbp_flash_protect fbp_chk #(
  .PROG_CYCLES(PROG_CYCLES),
  .FAST_CYCLES(FAST_CYCLES)
) chk_i (.*);
`default_nettype wire
